// File: shared/hpc_pkg.sv
// Shared constants and carrier types for the framed serial link controller
package hpc_pkg;

	// Data path width and packet buffer depth
	localparam int unsigned DATA_W       = 8;
	localparam int unsigned FIFO_DEPTH   = 19;
	localparam int unsigned ADDR_W       = 4;
	localparam int unsigned FLAG_W       = 5;

	// Register indices on the host port
	localparam logic [3:0] REG_FIFO      = 4'h0;
	localparam logic [3:0] REG_CTRL      = 4'h1;
	localparam logic [3:0] REG_STAT      = 4'h2;
	localparam logic [3:0] REG_IEN       = 4'h3;
	localparam logic [3:0] REG_IFLAG     = 4'h4;
	localparam logic [3:0] REG_CTL_TX    = 4'h5;
	localparam logic [3:0] REG_CTL_RX    = 4'h6;
	localparam logic [3:0] REG_WDOG      = 4'h7;

	// Control register field positions
	localparam int unsigned CTRL_EXT_MODE = 0;
	localparam int unsigned CTRL_DBL_RATE = 1;
	localparam int unsigned CTRL_CHAN_LSB = 2;
	localparam int unsigned CHAN_W        = 4;

	// Interrupt flag positions
	localparam int unsigned FLG_RX_BYTE   = 0;
	localparam int unsigned FLG_RX_OVER   = 1;
	localparam int unsigned FLG_TX_UNDER  = 2;
	localparam int unsigned FLG_CTL_RX    = 3;
	localparam int unsigned FLG_WDOG      = 4;

	// Frame layout: eight bits per timeslot, control channel slot
	localparam logic [4:0] SLOT_CTL       = 5'h01;
	localparam logic [2:0] BIT_LAST       = 3'h7;
	localparam logic [7:0] IDLE_BYTE      = 8'hFF;
	localparam logic [7:0] READ_ZERO      = 8'h00;

	// Link rate limit against the sampling clock
	localparam int unsigned SYS_CLK_KHZ   = 10000;
	localparam int unsigned MAX_RATE_KBPS = 2500;
	localparam int unsigned SYS_PER_BIT   = SYS_CLK_KHZ / MAX_RATE_KBPS;

	// Host microprocessor port pins
	typedef struct packed {
		logic                cs_n;
		logic                strobe;
		logic                rd_wr;
		logic [ADDR_W-1:0]   register_select;
		logic [DATA_W-1:0]   data;
	} hpc_host_s;

	// Serial link pins
	typedef struct packed {
		logic                serial_bit_clock;
		logic                frame_pulse;
		logic                tx_clock_gate_n;
		logic                rx_clock_gate_n;
		logic                serial_data_in;
	} hpc_link_s;

endpackage

// File: src/hpc_top.sv
// Framed serial link controller: host port, timeslot framer, watchdog, packet buffers
// What this block does
// - External mode transmits only while transmit gate is low; internal mode ignores it.
// - External mode drives serial output while transmit gate low, releases it while high; internal mode always drives it.
// - External mode receives only while receive gate low; internal ignores it.
// - Internal mode sends packet data in chosen slots 0,2,3,4; control in slot 1.
// - External mode shifts each output bit on rising serial clock while gate low.
// - External mode samples each input bit on falling serial clock while gate low.
// - Both directions use NRZ: high is one, low is zero, whole bit period.
// - Watchdog output high normally, low on expiry or while reset is held.
// - Interrupt pin pulled low only when a flag and its enable are both set.
// - Four select inputs choose a register together with select, direction, strobe.
// - Register access happens only while chip select is low.
// - Strobe qualifies address and direction; reads drive while strobe is high, writes land as strobe falls.
// - Direction high drives read data onto the bus; low takes write data.
// - Nineteen-byte packet buffer on transmit path and another on receive path.
// - Serial output supports bit rates up to 2.5 Mbit/s with a bit-rate clock, up to 1.25 Mbit/s with the double-rate clock.
// - Internal mode rate bit picks bit-rate or double-rate clock; external is bit-rate.
// - Frame pulse starts each internal frame and clocks the watchdog.
// - Reset clears all registers, both packet buffers and the watchdog.
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Packet buffer with show-ahead output
module hpc_fifo #(
	parameter int unsigned WIDTH = hpc_pkg::DATA_W,
	parameter int unsigned DEPTH = hpc_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic             clk_sys_in,
	input  wire logic             sys_rst_in,
	// Fill side
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	// Drain side
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic [WIDTH-1:0]      out_data_out
);
	import hpc_pkg::*;

	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

	typedef struct packed {
		logic [PW-1:0] wr;
		logic [PW-1:0] rd;
		logic [CW-1:0] cnt;
	} hpc_fifo_s;

	hpc_fifo_s        st_ff;
	hpc_fifo_s        nxt_st;
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic             push;
	logic             pop;

	// Honest full and empty from the fill count
	assign in_ready_out  = (st_ff.cnt != CW'(DEPTH));
	assign out_valid_out = (st_ff.cnt != '0);
	assign out_data_out  = mem_ff[st_ff.rd];
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_ready_in && out_valid_out;

	// Pointer and count update
	always_comb
	begin
		nxt_st = st_ff;
		if (push)
			nxt_st.wr = (st_ff.wr == PTR_LAST) ? '0 : st_ff.wr + 1'b1;
		if (pop)
			nxt_st.rd = (st_ff.rd == PTR_LAST) ? '0 : st_ff.rd + 1'b1;
		if (push && !pop)
			nxt_st.cnt = st_ff.cnt + 1'b1;
		else if (pop && !push)
			nxt_st.cnt = st_ff.cnt - 1'b1;
	end

	// State register, emptied by reset
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	// Storage array
	always_ff @(posedge clk_sys_in)
	begin
		if (push)
			mem_ff[st_ff.wr] <= in_data_in;
	end

endmodule

////////////////////////////////////////////////////////////////////////////////
// Controller top level
module hpc_top #(
	parameter int unsigned WD_W      = 16,
	parameter logic [15:0] WD_FRAMES = 16'h0400
) (
	// Clock and reset
	input  wire logic              clk_sys_in,
	input  wire logic              sys_rst_in,
	// Host microprocessor port
	input  wire hpc_pkg::hpc_host_s host_bus_in,
	output logic [7:0]             host_data_out,
	output logic                   host_data_oe_out,
	// Serial link
	input  wire hpc_pkg::hpc_link_s link_in,
	output logic                   serial_data_out,
	output logic                   serial_data_oe_out,
	// Watchdog and interrupt
	output logic                   watchdog_out_n,
	output logic                   interrupt_request_n_out,
	output logic                   interrupt_request_oe_out
);
	import hpc_pkg::*;

	typedef struct packed {
		hpc_host_s         h1, h2, h3, hs;
		hpc_link_s         l1, l2, l3, ls;
		logic              act;
		logic              rd_wr;
		logic [ADDR_W-1:0] sel;
		logic [7:0]        dout;
		logic              doe;
		logic              ext_mode;
		logic              dbl_rate;
		logic [CHAN_W-1:0] chan_en;
		logic [7:0]        ctl_tx;
		logic [7:0]        ctl_rx;
		logic [FLAG_W-1:0] ien;
		logic [FLAG_W-1:0] iflag;
		logic              phase;
		logic [7:0]        txcnt;
		logic [7:0]        rxcnt;
		logic [7:0]        tx_sh;
		logic [7:0]        rx_sh;
		logic              sdo;
		logic              sdo_oe;
		logic              irq_oe;
		logic [WD_W-1:0]   wd_cnt;
		logic              wd_exp;
		logic              wd_n;
	} hpc_state_s;

	hpc_state_s st_ff;
	hpc_state_s nxt_st;

	logic       tx_in_ready;
	logic       tx_out_valid;
	logic [7:0] tx_out_data;
	logic       rx_in_ready;
	logic       rx_out_valid;
	logic [7:0] rx_out_data;
	logic       tx_push;
	logic       tx_pop;
	logic       rx_push;
	logic       rx_pop;
	logic [7:0] rx_byte;

	// Timeslot enable lookup for data slots 0, 2, 3 and 4
	function automatic logic slot_on(input logic [4:0] slot, input logic [CHAN_W-1:0] en);
		logic r;
		r = 1'b0;
		case (slot)
			5'h00: r = en[0];
			5'h02: r = en[1];
			5'h03: r = en[2];
			5'h04: r = en[3];
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	// Transmit packet buffer
	hpc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.clk_sys_in    (clk_sys_in),
		.sys_rst_in    (sys_rst_in),
		.in_valid_in   (tx_push),
		.in_ready_out  (tx_in_ready),
		.in_data_in    (st_ff.hs.data),
		.out_valid_out (tx_out_valid),
		.out_ready_in  (tx_pop),
		.out_data_out  (tx_out_data)
	);

	// Receive packet buffer
	hpc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.clk_sys_in    (clk_sys_in),
		.sys_rst_in    (sys_rst_in),
		.in_valid_in   (rx_push),
		.in_ready_out  (rx_in_ready),
		.in_data_in    (rx_byte),
		.out_valid_out (rx_out_valid),
		.out_ready_in  (rx_pop),
		.out_data_out  (rx_out_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb
	begin
		logic       act_now;
		logic       wr_end;
		logic       frame_edge;
		logic       rise;
		logic       fall;
		logic       tx_go;
		logic       rx_go;
		logic [4:0] slot;
		logic [7:0] byte_out;
		logic [7:0] rx_new;
		logic [FLAG_W-1:0] set_f;
		logic [FLAG_W-1:0] clr_f;
		act_now    = 1'b0;
		wr_end     = 1'b0;
		frame_edge = 1'b0;
		rise       = 1'b0;
		fall       = 1'b0;
		tx_go      = 1'b0;
		rx_go      = 1'b0;
		slot       = '0;
		byte_out   = IDLE_BYTE;
		rx_new     = '0;
		set_f      = '0;
		clr_f      = '0;
		tx_push    = 1'b0;
		tx_pop     = 1'b0;
		rx_push    = 1'b0;
		rx_pop     = 1'b0;
		nxt_st     = st_ff;

		// Three-stage pin sampling; a bit changes once stages two and three agree
		nxt_st.h1 = host_bus_in;
		nxt_st.h2 = st_ff.h1;
		nxt_st.h3 = st_ff.h2;
		nxt_st.hs = hpc_host_s'((st_ff.h3 & ~(st_ff.h2 ^ st_ff.h3))
			| (st_ff.hs & (st_ff.h2 ^ st_ff.h3)));
		nxt_st.l1 = link_in;
		nxt_st.l2 = st_ff.l1;
		nxt_st.l3 = st_ff.l2;
		nxt_st.ls = hpc_link_s'((st_ff.l3 & ~(st_ff.l2 ^ st_ff.l3))
			| (st_ff.ls & (st_ff.l2 ^ st_ff.l3)));

		// Host access: strobe high with select low opens a cycle
		act_now   = st_ff.hs.strobe && !st_ff.hs.cs_n;
		nxt_st.act = act_now;
		if (act_now && !st_ff.act)
		begin
			nxt_st.rd_wr = st_ff.hs.rd_wr;
			nxt_st.sel   = st_ff.hs.register_select;
			case (st_ff.hs.register_select)
				REG_FIFO:   nxt_st.dout = rx_out_valid ? rx_out_data : READ_ZERO;
				REG_CTRL:   nxt_st.dout = {2'b00, st_ff.chan_en, st_ff.dbl_rate, st_ff.ext_mode};
				REG_STAT:   nxt_st.dout = {3'b000, st_ff.wd_exp, !rx_in_ready, !rx_out_valid,
					!tx_out_valid, !tx_in_ready};
				REG_IEN:    nxt_st.dout = {3'b000, st_ff.ien};
				REG_IFLAG:  nxt_st.dout = {3'b000, st_ff.iflag};
				REG_CTL_TX: nxt_st.dout = st_ff.ctl_tx;
				REG_CTL_RX: nxt_st.dout = st_ff.ctl_rx;
				default:    nxt_st.dout = READ_ZERO;
			endcase
		end
		nxt_st.doe = act_now && st_ff.hs.rd_wr;

		// Access ends on strobe fall; writes take the data bus as it stands then
		wr_end = st_ff.act && !act_now;
		if (wr_end && !st_ff.rd_wr)
		begin
			case (st_ff.sel)
				REG_FIFO:   tx_push = 1'b1;
				REG_CTRL:
				begin
					nxt_st.ext_mode = st_ff.hs.data[CTRL_EXT_MODE];
					nxt_st.dbl_rate = st_ff.hs.data[CTRL_DBL_RATE];
					nxt_st.chan_en  = st_ff.hs.data[CTRL_CHAN_LSB +: CHAN_W];
				end
				REG_IEN:    nxt_st.ien = st_ff.hs.data[FLAG_W-1:0];
				REG_IFLAG:  clr_f = st_ff.hs.data[FLAG_W-1:0];
				REG_CTL_TX: nxt_st.ctl_tx = st_ff.hs.data;
				REG_WDOG:   nxt_st.wd_cnt = '0;
				default:    nxt_st.ctl_tx = st_ff.ctl_tx;
			endcase
		end
		if (wr_end && st_ff.rd_wr && st_ff.sel == REG_FIFO)
			rx_pop = 1'b1;

		// Link clock edges: the filtered level is about to take the agreed new value
		rise       = !st_ff.ls.serial_bit_clock && st_ff.l2.serial_bit_clock
			&& st_ff.l3.serial_bit_clock;
		fall       = st_ff.ls.serial_bit_clock && !st_ff.l2.serial_bit_clock
			&& !st_ff.l3.serial_bit_clock;
		frame_edge = !st_ff.ls.frame_pulse && st_ff.l2.frame_pulse && st_ff.l3.frame_pulse;
		if (st_ff.ext_mode)
		begin
			tx_go = rise && !st_ff.ls.tx_clock_gate_n;
			rx_go = fall && !st_ff.ls.rx_clock_gate_n;
		end
		else
		begin
			tx_go = rise && (!st_ff.dbl_rate || !st_ff.phase);
			rx_go = fall && (!st_ff.dbl_rate || st_ff.phase);
			if (rise && st_ff.dbl_rate)
				nxt_st.phase = !st_ff.phase;
		end

		// Frame start realigns slot counters in internal mode
		if (frame_edge && !st_ff.ext_mode)
		begin
			nxt_st.txcnt = '0;
			nxt_st.rxcnt = '0;
			nxt_st.phase = 1'b0;
			tx_go        = 1'b0;
			rx_go        = 1'b0;
		end

		// Transmit: load a byte at each slot start, then shift out MSB first
		if (tx_go)
		begin
			slot = st_ff.txcnt[7:3];
			if (st_ff.txcnt[2:0] == '0)
			begin
				if (!st_ff.ext_mode && slot == SLOT_CTL)
					byte_out = st_ff.ctl_tx;
				else if (st_ff.ext_mode || slot_on(slot, st_ff.chan_en))
				begin
					if (tx_out_valid)
					begin
						byte_out = tx_out_data;
						tx_pop   = 1'b1;
					end
					else
						set_f[FLG_TX_UNDER] = 1'b1;
				end
				nxt_st.sdo   = byte_out[7];
				nxt_st.tx_sh = {byte_out[6:0], 1'b1};
			end
			else
			begin
				nxt_st.sdo   = st_ff.tx_sh[7];
				nxt_st.tx_sh = {st_ff.tx_sh[6:0], 1'b1};
			end
			nxt_st.txcnt = st_ff.txcnt + 1'b1;
		end
		nxt_st.sdo_oe = !st_ff.ext_mode || !st_ff.ls.tx_clock_gate_n;

		// Receive: assemble bytes and sort them by slot
		if (rx_go)
		begin
			rx_new       = {st_ff.rx_sh[6:0], st_ff.ls.serial_data_in};
			nxt_st.rx_sh = rx_new;
			nxt_st.rxcnt = st_ff.rxcnt + 1'b1;
			slot         = st_ff.rxcnt[7:3];
			if (st_ff.rxcnt[2:0] == BIT_LAST)
			begin
				if (!st_ff.ext_mode && slot == SLOT_CTL)
				begin
					nxt_st.ctl_rx     = rx_new;
					set_f[FLG_CTL_RX] = 1'b1;
				end
				else if (st_ff.ext_mode || slot_on(slot, st_ff.chan_en))
				begin
					rx_push = 1'b1;
					if (rx_in_ready)
						set_f[FLG_RX_BYTE] = 1'b1;
					else
						set_f[FLG_RX_OVER] = 1'b1;
				end
			end
		end

		// Watchdog advanced by frame pulses; expiry holds until reset
		if (frame_edge && !st_ff.wd_exp)
		begin
			if (st_ff.wd_cnt == WD_W'(WD_FRAMES - 16'h0001))
			begin
				nxt_st.wd_exp    = 1'b1;
				set_f[FLG_WDOG] = 1'b1;
			end
			else
				nxt_st.wd_cnt = st_ff.wd_cnt + 1'b1;
		end
		nxt_st.wd_n = !nxt_st.wd_exp;

		// Flags: a set in the clearing cycle wins
		nxt_st.iflag  = (st_ff.iflag & ~clr_f) | set_f;
		nxt_st.irq_oe = |(nxt_st.iflag & st_ff.ien);
	end

	// Byte pushed on the last bit must already hold that bit
	assign rx_byte = {st_ff.rx_sh[6:0], st_ff.ls.serial_data_in};

	////////////////////////////////////////////////////////////////////////////
	// State register; reset clears all and pulls the watchdog low
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	// Outputs straight from the state register; interrupt pin level tied low
	assign host_data_out            = st_ff.dout;
	assign host_data_oe_out         = st_ff.doe;
	assign serial_data_out          = st_ff.sdo;
	assign serial_data_oe_out       = st_ff.sdo_oe;
	assign watchdog_out_n           = st_ff.wd_n;
	assign interrupt_request_n_out  = 1'b0;
	assign interrupt_request_oe_out = st_ff.irq_oe;

endmodule

`default_nettype wire

// File: test/hdlc_controller_pin_interface_tb.sv
// Self-checking bench for the framed serial link controller
`timescale 1ns/100ps
`default_nettype none
module hdlc_controller_pin_interface_tb;
	import hpc_pkg::*;
	logic        clk_sys_in = 1'b0;
	logic        sys_rst_in = 1'b1;
	hpc_host_s   host_bus   = 16'h8000;
	hpc_link_s   link;
	logic [7:0]  host_data;
	logic        host_oe;
	logic        sdo;
	logic        sdo_oe;
	logic        wdog_n;
	logic        irq_n;
	logic        irq_oe;
	int          error_cnt = 0;
	int          samples_checked = 0;
	logic [63:0] got;
	logic [7:0]  rd;

	// 10 MHz system clock
	always #50 clk_sys_in = ~clk_sys_in;

	hpc_top #(.WD_FRAMES(16'h0004)) i_dut (
		.clk_sys_in               (clk_sys_in),
		.sys_rst_in               (sys_rst_in),
		.host_bus_in              (host_bus),
		.host_data_out            (host_data),
		.host_data_oe_out         (host_oe),
		.link_in                  (link),
		.serial_data_out          (sdo),
		.serial_data_oe_out       (sdo_oe),
		.watchdog_out_n           (wdog_n),
		.interrupt_request_n_out  (irq_n),
		.interrupt_request_oe_out (irq_oe)
	);

	hpc_link_peer i_peer (
		.link_out           (link),
		.serial_data_out_in (sdo),
		.serial_data_oe_in  (sdo_oe)
	);

	// Compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask

	// One host access; strobe held until read data is driven
	task automatic acc(input logic cs_n, input logic rw, input logic [3:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(negedge clk_sys_in);
		host_bus = {cs_n, 1'b0, rw, a, d};
		@(negedge clk_sys_in);
		host_bus.strobe = 1'b1;
		repeat (3) @(negedge clk_sys_in);
		for (int n = 0; n < 12 && rw && !cs_n && host_oe !== 1'b1; n++)
			@(negedge clk_sys_in);
		q = host_data;
		if (rw && !cs_n)
			check(16'(host_oe), 16'h0001);
		host_bus.strobe = 1'b0;
		repeat (6) @(negedge clk_sys_in);
		host_bus.cs_n = 1'b1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		acc(1'b0, 1'b0, a, d, rd);
	endtask

	task automatic rdc(input logic [3:0] a, input logic [7:0] e);
		acc(1'b0, 1'b1, a, 8'h00, rd);
		check(16'(rd), 16'(e));
	endtask

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Hang guard, well beyond the expected run of about 250 us
	initial
	begin
		#1000000;
		error_cnt++;
		report_and_stop();
	end

	// Main sequence
	initial
	begin
		repeat (16) @(negedge clk_sys_in);
		sys_rst_in = 1'b0;
		repeat (6) @(negedge clk_sys_in);
		check(16'(wdog_n), 16'h0001);
		rdc(REG_STAT, 8'h06);
		// Internal mode, gates closed: control byte in slot 1 both ways
		wr(REG_CTL_TX, 8'hC3);
		i_peer.shift(16, 64'hFF96, 1'b1, got);
		check(got[15:0], 16'hFFC3);
		check(16'(sdo_oe), 16'h0001);
		rdc(REG_CTL_RX, 8'h96);
		// External mode; a write with select high is ignored
		wr(REG_CTRL, 8'h01);
		acc(1'b1, 1'b0, REG_CTRL, 8'h00, rd);
		rdc(REG_CTRL, 8'h01);
		// Fill the transmit buffer past its depth while the link stalls
		for (int i = 1; i <= 18; i++)
			wr(REG_FIFO, 8'(i));
		rdc(REG_STAT, 8'h04);
		wr(REG_FIFO, 8'h13);
		wr(REG_FIFO, 8'hEE);
		rdc(REG_STAT, 8'h05);
		i_peer.shift(8, 64'h0, 1'b0, got);
		check(16'(sdo_oe), 16'h0000);
		// Drain through the open transmit gate, MSB first
		i_peer.gates(1'b0, 1'b1);
		for (int i = 1; i <= 19; i++)
		begin
			i_peer.shift(8, 64'h0, 1'b0, got);
			check(got[15:0], 16'(i));
		end
		rdc(REG_STAT, 8'h06);
		// Receive: bits with the gate closed never land
		i_peer.gates(1'b1, 1'b1);
		i_peer.shift(8, 64'h0F, 1'b0, got);
		i_peer.gates(1'b1, 1'b0);
		i_peer.shift(8, 64'h5A, 1'b0, got);
		rdc(REG_FIFO, 8'h5A);
		rdc(REG_FIFO, 8'h00);
		// Watchdog expiry raises the enabled interrupt
		wr(REG_WDOG, 8'h00);
		wr(REG_IEN, 8'h10);
		repeat (3) i_peer.shift(0, 64'h0, 1'b1, got);
		check(16'(wdog_n), 16'h0001);
		check(16'(irq_oe), 16'h0000);
		repeat (2) i_peer.shift(0, 64'h0, 1'b1, got);
		check(16'(wdog_n), 16'h0000);
		check(16'({irq_oe, irq_n}), 16'h0002);
		wr(REG_IEN, 8'h00);
		check(16'(irq_oe), 16'h0000);
		wr(REG_WDOG, 8'h00);
		wr(REG_IFLAG, 8'h10);
		wr(REG_IEN, 8'h10);
		check(16'(irq_oe), 16'h0000);
		// Second reset in mid-run
		@(negedge clk_sys_in);
		sys_rst_in = 1'b1;
		repeat (4) @(negedge clk_sys_in);
		check(16'(wdog_n), 16'h0000);
		sys_rst_in = 1'b0;
		repeat (6) @(negedge clk_sys_in);
		rdc(REG_CTRL, 8'h00);
		// Internal double rate: one bit every two clocks, both ways
		wr(REG_CTRL, 8'h02);
		wr(REG_CTL_TX, 8'hC3);
		i_peer.shift(32, 64'hFFFF0FF0, 1'b1, got);
		check(got[31:16], 16'hFFFF);
		check(got[15:0], 16'hF00F);
		rdc(REG_CTL_RX, 8'h3C);
		report_and_stop();
	end
endmodule
`default_nettype wire

// File: test/hpc_chk.sv
// Port-level assertions for the framed serial link controller
`timescale 1ns/100ps
`default_nettype none
module hpc_chk
	import hpc_pkg::*;
(
	// Clock and reset
	input  wire logic               clk_sys_in,
	input  wire logic               sys_rst_in,
	// Host port
	input  wire hpc_pkg::hpc_host_s host_bus_in,
	input  wire logic [7:0]         host_data_out,
	input  wire logic               host_data_oe_out,
	// Serial link
	input  wire hpc_pkg::hpc_link_s link_in,
	input  wire logic               serial_data_out,
	input  wire logic               serial_data_oe_out,
	// Watchdog and interrupt
	input  wire logic               watchdog_out_n,
	input  wire logic               interrupt_request_n_out,
	input  wire logic               interrupt_request_oe_out
);
	typedef struct packed {
		logic       pin;
		logic [3:0] age;
	} hpc_chk_s;

	hpc_chk_s st_ff;
	hpc_chk_s nxt_st;

	// Age in cycles since the raw bit clock pin last rose
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.pin = link_in.serial_bit_clock;
		if (link_in.serial_bit_clock && !st_ff.pin)
			nxt_st.age = 4'h0;
		else if (st_ff.age != 4'hF)
			nxt_st.age = st_ff.age + 4'h1;
	end

	// Helper register
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (sys_rst_in);

	// Host access sequences held long enough for the pin sampler
	sequence s_host_idle;
		(!(host_bus_in.strobe && !host_bus_in.cs_n))[*7];
	endsequence
	sequence s_read_held;
		(host_bus_in.strobe && !host_bus_in.cs_n && host_bus_in.rd_wr)[*4];
	endsequence

	a_wdog_in_reset: assert property ($past(sys_rst_in) |-> !watchdog_out_n)
		else $error("watchdog output high straight after reset");
	a_wdog_release: assert property ($fell(sys_rst_in) |-> ##[1:3] watchdog_out_n)
		else $error("watchdog output not released after reset");
	a_reset_drv_off: assert property ($past(sys_rst_in) |->
		!host_data_oe_out && !interrupt_request_oe_out)
		else $error("driver enabled straight after reset");
	a_irq_open_drain: assert property (interrupt_request_oe_out |-> !interrupt_request_n_out)
		else $error("interrupt pin driven high");
	a_bus_idle_off: assert property (s_host_idle |=> !host_data_oe_out)
		else $error("data bus driven without select and strobe");
	a_read_drives: assert property (s_read_held |-> ##2 host_data_oe_out)
		else $error("read access does not drive data bus");
	a_write_no_drive: assert property ((!host_bus_in.rd_wr)[*7] |=> !host_data_oe_out)
		else $error("data bus driven during write direction");
	a_tx_gate_drive: assert property ((!link_in.tx_clock_gate_n)[*7] |=> serial_data_oe_out)
		else $error("serial output released while transmit gate low");
	a_bit_on_rise: assert property ($changed(serial_data_out) |-> st_ff.age <= 4'h4)
		else $error("serial output changed away from a clock rise");
endmodule

bind hpc_top hpc_chk i_chk (
	.clk_sys_in               (clk_sys_in),
	.sys_rst_in               (sys_rst_in),
	.host_bus_in              (host_bus_in),
	.host_data_out            (host_data_out),
	.host_data_oe_out         (host_data_oe_out),
	.link_in                  (link_in),
	.serial_data_out          (serial_data_out),
	.serial_data_oe_out       (serial_data_oe_out),
	.watchdog_out_n           (watchdog_out_n),
	.interrupt_request_n_out  (interrupt_request_n_out),
	.interrupt_request_oe_out (interrupt_request_oe_out)
);
`default_nettype wire

// File: test/hpc_link_peer.sv
// Far-end model of the serial link: bit clock, frame pulse, gates and data
`timescale 1ns/100ps
`default_nettype none
module hpc_link_peer
	import hpc_pkg::*;
(
	output var hpc_pkg::hpc_link_s link_out,
	input  wire logic              serial_data_out_in,
	input  wire logic              serial_data_oe_in
);
	// Clock low, frame low, both gates closed, data high
	initial link_out = 5'h07;

	// Open or close the transmit and receive gates
	task automatic gates(input logic tx_n, input logic rx_n);
		link_out.tx_clock_gate_n = tx_n;
		link_out.rx_clock_gate_n = rx_n;
	endtask

	// Optional frame pulse, then n bits at 800 ns each, clock still outside
	task automatic shift(input int n, input logic [63:0] rx, input logic fr,
		output logic [63:0] tx);
		tx = 64'h0;
		if (fr)
		begin
			link_out.frame_pulse = 1'b1;
			#400;
			link_out.frame_pulse = 1'b0;
		end
		for (int i = 0; i < n; i++)
		begin
			#400;
			if (i > 0)
				tx = {tx[62:0], serial_data_oe_in ? serial_data_out_in : 1'bx};
			link_out.serial_bit_clock = 1'b1;
			link_out.serial_data_in = rx[n-1-i];
			#400;
			link_out.serial_bit_clock = 1'b0;
		end
		#400;
		if (n > 0)
			tx = {tx[62:0], serial_data_oe_in ? serial_data_out_in : 1'bx};
		// Released line shows the inverse so a stale bit is never trusted
		link_out.serial_data_in = ~link_out.serial_data_in;
	endtask
endmodule
`default_nettype wire
